// >>> shared/ldc_pkg.sv
// Constants and types for the low-side diagnostic and configuration register bank
package ldc_pkg;

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int          LDC_STAGES      = 18;
    localparam int          LDC_CODE_W      = 2 * LDC_STAGES;
    localparam int          LDC_SEL_NUM     = 6;
    localparam int          LDC_CMD_BITS    = 8;
    localparam int          LDC_FRAME_BITS  = 16;

    // ----------------------------------------------------------------
    // Reset values and fixed bits
    // ----------------------------------------------------------------
    localparam logic [7:0]  LDC_FAULT_RST   = 8'hff;
    localparam logic [7:0]  LDC_CFG_RST     = 8'hff;
    localparam logic [7:0]  LDC_CFG_FIXED   = 8'h01;
    localparam logic [7:0]  LDC_FILL        = 8'hff;
    localparam logic [2:0]  LDC_FS5_UNUSED  = 3'h7;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          LDC_CFG_SRC_BIT = 1;
    localparam int          LDC_CFG_SEL_LSB = 2;
    localparam int          LDC_FS5_BATT    = 4;

    // ----------------------------------------------------------------
    // Stage fault codes
    // ----------------------------------------------------------------
    localparam logic [1:0]  LDC_CODE_OK     = 2'h3;
    localparam logic [1:0]  LDC_CODE_SCB    = 2'h2;
    localparam logic [1:0]  LDC_CODE_OL     = 2'h1;
    localparam logic [1:0]  LDC_CODE_SCG    = 2'h0;

    // ----------------------------------------------------------------
    // Serial instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0]  LDC_CMD_RD_FS1  = 8'h01;
    localparam logic [7:0]  LDC_CMD_RD_FS2  = 8'h02;
    localparam logic [7:0]  LDC_CMD_RD_FS3  = 8'h03;
    localparam logic [7:0]  LDC_CMD_RD_FS4  = 8'h04;
    localparam logic [7:0]  LDC_CMD_RD_FS5  = 8'h05;
    localparam logic [7:0]  LDC_CMD_RD_CFG  = 8'h06;
    localparam logic [7:0]  LDC_CMD_WR_CFG  = 8'h07;
    localparam logic [7:0]  LDC_CMD_CLEAR   = 8'h08;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic csN;
        logic sclk;
        logic mosi;
    } ldc_spi_t;

    typedef enum logic {LDC_ST_IDLE, LDC_ST_FRAME} ldc_state_t;

endpackage

// >>> src/ldc_diag_config_regs.sv
// Fault status and configuration register bank reached over the serial link
`timescale 1ns/1ps

module ldc_diag_config_regs
    import ldc_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    srst,
    input  wire logic                    spiCsN,
    input  wire logic                    spiSclk,
    input  wire logic                    spiMosi,
    output logic                         spiMiso,
    output logic                         spiMisoOe,
    input  wire logic [LDC_CODE_W-1:0]   stageFaultCode,
    input  wire logic                    batteryAbove,
    output logic                         controlSourceSelect,
    output logic                         pullupEnable,
    output logic [LDC_SEL_NUM-1:0]       stageShortShutoff,
    output logic [LDC_SEL_NUM-1:0]       filterRestart
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic int selStage(input int idx);
        case (idx)
            0:       selStage = 17;
            1:       selStage = 18;
            2:       selStage = 9;
            3:       selStage = 10;
            4:       selStage = 15;
            default: selStage = 16;
        endcase
    endfunction

    function automatic logic [1:0] stageCode(input logic [LDC_CODE_W-1:0] codes, input int stage);
        stageCode = codes[2*stage-2 +: 2];
    endfunction

    function automatic logic [7:0] readMux(input logic [7:0]            cmdCode,
                                           input logic [LDC_CODE_W-1:0] faults,
                                           input logic                  batt,
                                           input logic [7:0]            cfgVal);
        case (cmdCode)
            LDC_CMD_RD_FS1: readMux = faults[7:0];
            LDC_CMD_RD_FS2: readMux = faults[15:8];
            LDC_CMD_RD_FS3: readMux = faults[23:16];
            LDC_CMD_RD_FS4: readMux = faults[31:24];
            LDC_CMD_RD_FS5: readMux = {LDC_FS5_UNUSED, batt, faults[35:32]};
            LDC_CMD_RD_CFG: readMux = cfgVal;
            default:        readMux = LDC_FILL;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    ldc_spi_t                  spiMeta;
    ldc_spi_t                  spiSync;
    logic                      sclkPrev;
    logic [LDC_CODE_W-1:0]     faultMeta;
    logic [LDC_CODE_W-1:0]     faultSync;
    logic                      battMeta;
    logic                      battSync;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            spiMeta   <= '{csN: 1'b1, sclk: 1'b0, mosi: 1'b0};
            spiSync   <= '{csN: 1'b1, sclk: 1'b0, mosi: 1'b0};
            sclkPrev  <= 1'b0;
            faultMeta <= '1;
            faultSync <= '1;
            battMeta  <= 1'b0;
            battSync  <= 1'b0;
        end
        else
        begin
            spiMeta   <= '{csN: spiCsN, sclk: spiSclk, mosi: spiMosi};
            spiSync   <= spiMeta;
            sclkPrev  <= spiSync.sclk;
            faultMeta <= stageFaultCode;
            faultSync <= faultMeta;
            battMeta  <= batteryAbove;
            battSync  <= battMeta;
        end
    end

    logic sclkRise;
    logic sclkFall;

    assign sclkRise = spiSync.sclk & ~sclkPrev;
    assign sclkFall = ~spiSync.sclk & sclkPrev;

    // ----------------------------------------------------------------
    // Frame engine and register state
    // ----------------------------------------------------------------
    ldc_state_t                state;
    ldc_state_t                next_state;
    logic [4:0]                bitCnt;
    logic [4:0]                next_bitCnt;
    logic [7:0]                shiftIn;
    logic [7:0]                next_shiftIn;
    logic [7:0]                txShift;
    logic [7:0]                next_txShift;
    logic [7:0]                cmd;
    logic [7:0]                next_cmd;
    logic [7:0]                cfg;
    logic [7:0]                next_cfg;
    logic [LDC_CODE_W-1:0]     faultReg;
    logic [LDC_CODE_W-1:0]     next_faultReg;
    logic [LDC_SEL_NUM-1:0]    next_shutoff;
    logic [LDC_SEL_NUM-1:0]    next_restart;
    logic [LDC_SEL_NUM-1:0]    scbSel;
    logic [7:0]                rxByte;
    logic                      loadRead;
    logic                      cfgWrite;
    logic                      clearPulse;

    assign rxByte = {shiftIn[6:0], spiSync.mosi};

    always_comb
    begin
        for (int i = 0; i < LDC_SEL_NUM; i++)
        begin
            scbSel[i] = (stageCode(faultSync, selStage(i)) == LDC_CODE_SCB)
                        && cfg[LDC_CFG_SEL_LSB + i];
        end
    end

    always_comb
    begin
        next_state    = state;
        next_bitCnt   = bitCnt;
        next_shiftIn  = shiftIn;
        next_txShift  = txShift;
        next_cmd      = cmd;
        next_cfg      = cfg;
        next_faultReg = faultReg & faultSync;
        next_shutoff  = stageShortShutoff | scbSel;
        next_restart  = '0;
        loadRead      = 1'b0;
        cfgWrite      = 1'b0;
        clearPulse    = 1'b0;
        case (state)
            LDC_ST_IDLE:
            begin
                if (!spiSync.csN)
                begin
                    next_state   = LDC_ST_FRAME;
                    next_bitCnt  = '0;
                    next_txShift = LDC_FILL;
                end
            end
            LDC_ST_FRAME:
            begin
                if (spiSync.csN)
                begin
                    next_state = LDC_ST_IDLE;
                end
                else if (sclkRise && bitCnt < 5'(LDC_FRAME_BITS))
                begin
                    next_shiftIn = rxByte;
                    next_bitCnt  = bitCnt + 5'd1;
                    if (bitCnt == 5'(LDC_CMD_BITS - 1))
                    begin
                        next_cmd     = rxByte;
                        loadRead     = 1'b1;
                        next_txShift = readMux(rxByte, faultReg, battSync, cfg);
                    end
                    if (bitCnt == 5'(LDC_FRAME_BITS - 1))
                    begin
                        cfgWrite   = (cmd == LDC_CMD_WR_CFG);
                        clearPulse = (cmd == LDC_CMD_CLEAR);
                    end
                end
                else if (sclkFall && bitCnt > 5'(LDC_CMD_BITS) && bitCnt < 5'(LDC_FRAME_BITS))
                begin
                    next_txShift = {txShift[6:0], 1'b1};
                end
            end
            default:
            begin
                next_state = LDC_ST_IDLE;
            end
        endcase
        if (cfgWrite)
        begin
            next_cfg = rxByte | LDC_CFG_FIXED;
        end
        if (clearPulse)
        begin
            next_faultReg = faultSync;
            next_restart  = stageShortShutoff;
            next_shutoff  = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state             <= LDC_ST_IDLE;
            bitCnt            <= '0;
            shiftIn           <= '0;
            txShift           <= LDC_FILL;
            cmd               <= '0;
            cfg               <= LDC_CFG_RST;
            faultReg          <= LDC_CODE_W'({5{LDC_FAULT_RST}});
            stageShortShutoff <= '0;
            filterRestart     <= '0;
        end
        else
        begin
            state             <= next_state;
            bitCnt            <= next_bitCnt;
            shiftIn           <= next_shiftIn;
            txShift           <= next_txShift;
            cmd               <= next_cmd;
            cfg               <= next_cfg;
            faultReg          <= next_faultReg;
            stageShortShutoff <= next_shutoff;
            filterRestart     <= next_restart;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign spiMiso             = txShift[7];
    assign spiMisoOe           = (state == LDC_ST_FRAME);
    assign controlSourceSelect = cfg[LDC_CFG_SRC_BIT];
    assign pullupEnable        = cfg[LDC_CFG_SRC_BIT];

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence seqClearSeen;
        clearPulse;
    endsequence

    sequence seqRestored;
        (faultReg == $past(faultSync)) && (stageShortShutoff == '0);
    endsequence

    AST_RESET_FAULT: assert property (@(posedge ref_clk) srst |=> (faultReg == '1) && (cfg == LDC_CFG_RST))
        else $error("fault or config register not all ones after reset");

    AST_STICKY_LOW: assert property (@(posedge ref_clk) disable iff (srst)
        !clearPulse |=> (faultReg & ~$past(faultSync)) == '0)
        else $error("fault code bit lost while fault present");

    AST_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) seqClearSeen |=> seqRestored)
        else $error("clear did not restore fault bits to live inputs");

    AST_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
        seqClearSeen |=> filterRestart == $past(stageShortShutoff) ##1 filterRestart == '0)
        else $error("filter restart pulse wrong after clear");

    AST_SHUTOFF: assert property (@(posedge ref_clk) disable iff (srst)
        (!clearPulse && scbSel != '0) |=> (stageShortShutoff & $past(scbSel)) == $past(scbSel))
        else $error("selected stage not shut off on battery short");

    AST_FS5_READ: assert property (@(posedge ref_clk) disable iff (srst)
        (loadRead && rxByte == LDC_CMD_RD_FS5) |=>
            txShift[7:5] == LDC_FS5_UNUSED && txShift[LDC_FS5_BATT] == $past(battSync))
        else $error("fifth fault register read wrong");

    AST_FS5_CODES: assert property (@(posedge ref_clk) disable iff (srst)
        (loadRead && rxByte == LDC_CMD_RD_FS5) |=> txShift[3:0] == $past(faultReg[35:32]))
        else $error("fifth fault register stage codes wrong");

    AST_CFG_READ: assert property (@(posedge ref_clk) disable iff (srst)
        (loadRead && rxByte == LDC_CMD_RD_CFG) |=> txShift[0] == 1'b1 && txShift == cfg)
        else $error("config readback wrong");

    AST_CFG_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
        cfgWrite |=> controlSourceSelect == $past(shiftIn[0]) && pullupEnable == controlSourceSelect)
        else $error("control source select not taken from write");

    AST_FRAME_END: assert property (@(posedge ref_clk) disable iff (srst)
        (state == LDC_ST_FRAME && spiSync.csN) |=> !spiMisoOe)
        else $error("data out still driven after frame");

endmodule

// >>> testbench/ldc_host_model.sv
// Host-side serial master model that runs frames into the register bank
`timescale 1ns/1ps

module ldc_host_model
    import ldc_pkg::*;
(
    input  wire logic ref_clk,
    output ldc_spi_t  spiOut,
    input  wire logic spiMiso
);
    // ----------------------------------------------------------------
    // Frame driver
    // ----------------------------------------------------------------
    localparam int HALF = 4;

    initial
    begin
        spiOut = '{csN: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end

    // Instruction byte then data byte, MSB first; link clock idles low outside frames
    task automatic xfer(input logic [7:0] instr, input logic [7:0] data, output logic [7:0] rdData);
        logic [15:0] frame;
        frame = {instr, data};
        rdData = 8'h00;
        @(negedge ref_clk);
        spiOut.csN = 1'b0;
        repeat (HALF) @(negedge ref_clk);
        for (int b = 15; b >= 0; b--)
        begin
            spiOut.mosi = frame[b];
            repeat (HALF / 2) @(negedge ref_clk);
            if (b < 8)
            begin
                rdData[b] = spiMiso;
            end
            spiOut.sclk = 1'b1;
            repeat (HALF) @(negedge ref_clk);
            spiOut.sclk = 1'b0;
            repeat (HALF / 2) @(negedge ref_clk);
        end
        repeat (HALF) @(negedge ref_clk);
        spiOut.csN = 1'b1;
        // Released data line toggles so a stale level is never mistaken for data
        spiOut.mosi = ~spiOut.mosi;
        repeat (HALF) @(negedge ref_clk);
    endtask
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the fault status and configuration register bank
`timescale 1ns/1ps

module tb_top
    import ldc_pkg::*;
;
    logic                  ref_clk;
    logic                  srst;
    ldc_spi_t              spi;
    logic                  spiMiso;
    logic                  spiMisoOe;
    logic [LDC_CODE_W-1:0] stageFaultCode;
    logic                  batteryAbove;
    logic                  controlSourceSelect;
    logic                  pullupEnable;
    logic [LDC_SEL_NUM-1:0] stageShortShutoff;
    logic [LDC_SEL_NUM-1:0] filterRestart;
    logic [LDC_SEL_NUM-1:0] restartSeen;
    logic                  seenClr;
    int                    errCount;
    int                    numChecks;
    int                    selStage [6] = '{17, 18, 9, 10, 15, 16};

    ldc_diag_config_regs i_dut (.ref_clk(ref_clk), .srst(srst), .spiCsN(spi.csN), .spiSclk(spi.sclk),
        .spiMosi(spi.mosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .stageFaultCode(stageFaultCode),
        .batteryAbove(batteryAbove), .controlSourceSelect(controlSourceSelect), .pullupEnable(pullupEnable),
        .stageShortShutoff(stageShortShutoff), .filterRestart(filterRestart));

    ldc_host_model i_host (.ref_clk(ref_clk), .spiOut(spi), .spiMiso(spiMiso));

    // ----------------------------------------------------------------
    // Clock, pulse catcher, checking tasks
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) restartSeen <= seenClr ? '0 : (restartSeen | filterRestart);

    task automatic tally_and_finish();
        if (errCount == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check6(input logic [5:0] got, input logic [5:0] exp);
        check8({2'h0, got}, {2'h0, exp});
    endtask

    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        logic [7:0] val;
        i_host.xfer(cmd, 8'h00, val);
        check8(val, exp);
    endtask

    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        logic [7:0] val;
        i_host.xfer(cmd, data, val);
    endtask

    task automatic setCode(input int s, input logic [1:0] c);
        @(negedge ref_clk);
        stageFaultCode[2*s-2 +: 2] = c;
    endtask

    function automatic logic [7:0] expVal(input int s, input logic [1:0] c);
        logic [7:0] v;
        v = 8'hff;
        v[2*((s-1)%4) +: 2] = c;
        return v;
    endfunction

    function automatic logic [7:0] regCmd(input int s);
        return LDC_CMD_RD_FS1 + 8'((s - 1) / 4);
    endfunction

    task automatic waitShut(input logic [5:0] exp);
        int n;
        n = 0;
        while (stageShortShutoff !== exp && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (stageShortShutoff !== exp)
        begin
            errCount++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (100000) @(posedge ref_clk);
        errCount++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        batteryAbove = 1'b1;
        stageFaultCode = '1;
        seenClr = 1'b0;
        errCount = 0;
        numChecks = 0;
        repeat (16) @(negedge ref_clk);
        srst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check8({6'h0, controlSourceSelect, pullupEnable}, 8'h03);
        check6(stageShortShutoff, 6'h00);
        check8({7'h0, spiMisoOe}, 8'h00);
        for (int r = 0; r < 5; r++)
            rd(LDC_CMD_RD_FS1 + 8'(r), 8'hff);
        rd(LDC_CMD_RD_CFG, 8'hff);
        rd(8'h00, 8'hff);
        batteryAbove = 1'b0;
        rd(LDC_CMD_RD_FS5, 8'hef);
        batteryAbove = 1'b1;
        rd(LDC_CMD_RD_FS5, 8'hff);
        for (int s = 1; s <= LDC_STAGES; s++)
        begin
            setCode(s, 2'(s % 3));
            repeat (8) @(negedge ref_clk);
            setCode(s, LDC_CODE_OK);
            rd(regCmd(s), expVal(s, 2'(s % 3)));
            wr(LDC_CMD_CLEAR, 8'h00);
            rd(regCmd(s), 8'hff);
        end
        setCode(1, LDC_CODE_SCG);
        wr(LDC_CMD_CLEAR, 8'h00);
        rd(LDC_CMD_RD_FS1, expVal(1, LDC_CODE_SCG));
        setCode(1, LDC_CODE_SCB);
        repeat (10) @(negedge ref_clk);
        check6(stageShortShutoff, 6'h00);
        setCode(1, LDC_CODE_OK);
        wr(LDC_CMD_CLEAR, 8'h00);
        rd(LDC_CMD_RD_FS1, 8'hff);
        wr(LDC_CMD_WR_CFG, 8'h00);
        rd(LDC_CMD_RD_CFG, 8'h01);
        check8({6'h0, controlSourceSelect, pullupEnable}, 8'h00);
        wr(LDC_CMD_WR_CFG, 8'h03);
        rd(LDC_CMD_RD_CFG, 8'h03);
        for (int i = 0; i < 6; i++)
            setCode(selStage[i], LDC_CODE_SCB);
        repeat (10) @(negedge ref_clk);
        check6(stageShortShutoff, 6'h00);
        for (int i = 0; i < 6; i++)
            setCode(selStage[i], LDC_CODE_OK);
        wr(LDC_CMD_CLEAR, 8'h00);
        wr(LDC_CMD_WR_CFG, 8'hff);
        for (int i = 0; i < 6; i++)
        begin
            setCode(selStage[i], LDC_CODE_SCB);
            waitShut(6'(1 << i));
            check6(stageShortShutoff, 6'(1 << i));
            setCode(selStage[i], LDC_CODE_OK);
            seenClr = 1'b1;
            @(negedge ref_clk);
            seenClr = 1'b0;
            wr(LDC_CMD_CLEAR, 8'h00);
            check6(stageShortShutoff, 6'h00);
            check6(restartSeen, 6'(1 << i));
        end
        wr(LDC_CMD_WR_CFG, 8'h00);
        setCode(2, LDC_CODE_OL);
        repeat (4) @(negedge ref_clk);
        setCode(2, LDC_CODE_OK);
        repeat (4) @(negedge ref_clk);
        rd(LDC_CMD_RD_FS1, expVal(2, LDC_CODE_OL));
        srst = 1'b1;
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        repeat (4) @(negedge ref_clk);
        check8({6'h0, controlSourceSelect, pullupEnable}, 8'h03);
        rd(LDC_CMD_RD_FS1, 8'hff);
        rd(LDC_CMD_RD_CFG, 8'hff);
        tally_and_finish();
    end
endmodule
